// ---- logic/imd_decoder.sv ----
// I/O and memory address decoder with APB configuration registers
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module imd_decoder (
  input  wire logic              pclk,       // clock, 200 MHz
  input  wire logic              presetn,    // async reset, low
  input  wire logic              ce,         // clock enable, freezes all state
  input  wire logic [11:0]       paddr,      // apb byte address
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic              pwrite,     // apb direction
  input  wire logic [31:0]       pwdata,     // apb write data
  input  wire logic [3:0]        pstrb,      // apb byte strobes
  output logic      [31:0]       prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error, unmapped
  input  wire logic              req_valid,  // cycle to decode
  input  wire imd_pkg::imd_req_t req,        // cycle address and kind
  output logic                   req_ready,  // cycle taken
  output logic                   rsp_valid,  // decision valid
  output imd_pkg::imd_rsp_t      rsp         // decision
);

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic [31:0] fwen_q, apic_q, pae_q, leg_q, lan_q;
  logic [31:0] own_rd_q;
  logic        tbl_sel_q;
  logic [15:0] abort_cnt_q;
  logic        rsp_valid_q;
  imd_pkg::imd_rsp_t rsp_q, rsp_d;
  logic [31:0] tbl_rd;
  logic [imd_pkg::NUM_ENT-1:0][31:0] ent;

  wire setup_ph = psel & ~penable;
  wire acc_ph   = psel & penable;
  wire wr_acc   = ce & acc_ph & pwrite;
  wire aligned  = paddr[1:0] == 2'b00;
  wire hit_fwen = paddr == imd_pkg::FWEN_OFF;
  wire hit_apic = paddr == imd_pkg::APIC_OFF;
  wire hit_pae  = paddr == imd_pkg::PAE_OFF;
  wire hit_leg  = paddr == imd_pkg::LEG_OFF;
  wire hit_lan  = paddr == imd_pkg::LAN_OFF;
  wire hit_stat = paddr == imd_pkg::STAT_OFF;
  wire hit_tbl  = aligned && paddr[11:8] == imd_pkg::TBL_OFF[11:8]
                  && paddr[7:2] < 6'(imd_pkg::NUM_ENT);
  wire [4:0] tbl_idx = paddr[6:2];
  wire unmapped = ~(hit_fwen | hit_apic | hit_pae | hit_leg | hit_lan | hit_stat | hit_tbl);

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // zero wait states: read data is loaded during the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc_ph & unmapped;
  assign prdata  = tbl_sel_q ? tbl_rd : own_rd_q;

  wire [31:0] stat_word = {8'h00, abort_cnt_q, rsp_q.idx, rsp_q.tgt};
  wire [31:0] own_rd = hit_fwen ? fwen_q :
                       hit_apic ? apic_q :
                       hit_pae  ? pae_q  :
                       hit_leg  ? leg_q  :
                       hit_lan  ? lan_q  :
                       hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwen_q <= imd_pkg::FWEN_RST;
      apic_q <= imd_pkg::APIC_RST;
      pae_q  <= imd_pkg::PAE_RST;
      leg_q  <= imd_pkg::LEG_RST;
      lan_q  <= imd_pkg::LAN_RST;
    end else if (wr_acc) begin
      if (hit_fwen) fwen_q <= wmerge(fwen_q, pwdata, pstrb);
      if (hit_apic) apic_q <= wmerge(apic_q, pwdata, pstrb);
      if (hit_pae)  pae_q  <= wmerge(pae_q, pwdata, pstrb);
      if (hit_leg)  leg_q  <= wmerge(leg_q, pwdata, pstrb);
      if (hit_lan)  lan_q  <= wmerge(lan_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_rd_q  <= 32'h0000_0000;
      tbl_sel_q <= 1'b0;
    end else if (ce && setup_ph) begin
      own_rd_q  <= own_rd;
      tbl_sel_q <= hit_tbl;
    end
  end

  imd_win_table #(
    .N   (imd_pkg::NUM_ENT),
    .RST (imd_pkg::ENT_RST)
  ) u_tbl (
    .clk     (pclk),
    .rst_n   (presetn),
    .ce      (ce),
    .wr_en   (wr_acc & hit_tbl),
    .wr_idx  (tbl_idx),
    .wr_data (wmerge(ent[tbl_idx], pwdata, pstrb)),
    .rd_en   (setup_ph & hit_tbl),
    .rd_idx  (tbl_idx),
    .rd_data (tbl_rd),
    .ent     (ent)
  );

  // ****************************************************************
  // window matching, all combinational on present settings
  // ****************************************************************
  wire [15:0] io_a = req.addr[15:0];
  wire [31:0] ma   = req.addr;
  wire        up   = ~req.from_down;

  // legacy selectable windows; unused select codes close the window
  wire [1:0]  par_sel  = leg_q[imd_pkg::PAR_SEL_LSB +: 2];
  wire [2:0]  ser1_sel = leg_q[imd_pkg::SER1_SEL_LSB +: 3];
  wire [2:0]  ser2_sel = leg_q[imd_pkg::SER2_SEL_LSB +: 3];
  wire        fdc_sel  = leg_q[imd_pkg::FDC_SEL_BIT];
  wire [15:0] par_off  = io_a - imd_pkg::PAR_LOC[(par_sel == 2'd3) ? 2'd0 : par_sel];
  wire [15:0] ser1_off = io_a - imd_pkg::SER_LOC[ser1_sel];
  wire [15:0] ser2_off = io_a - imd_pkg::SER_LOC[ser2_sel];
  wire [15:0] fdc_off  = io_a - imd_pkg::FDC_LOC[fdc_sel];
  wire par_hit  = leg_q[imd_pkg::PAR_EN_BIT] && par_sel != 2'd3 && par_off[15:3] == 13'h0000;
  wire ser1_hit = leg_q[imd_pkg::SER1_EN_BIT] && ser1_off[15:3] == 13'h0000;
  wire ser2_hit = leg_q[imd_pkg::SER2_EN_BIT] && ser2_off[15:3] == 13'h0000;
  wire fdc_hit  = leg_q[imd_pkg::FDC_EN_BIT] && fdc_off[15:3] == 13'h0000;
  wire leg_any  = par_hit | ser1_hit | ser2_hit | fdc_hit;
  wire [3:0] leg_idx = par_hit ? 4'h0 : ser1_hit ? 4'h1 : ser2_hit ? 4'h2 : 4'h3;

  // root port and variable I/O windows, then bridge memory windows
  logic [imd_pkg::NUM_IOW-1:0] io_hit;
  logic [imd_pkg::NUM_RP-1:0]  br_hit;

  for (genvar i = 0; i < imd_pkg::NUM_IOW; i++) begin : g_io
    imd_range_hit #(.W(16)) u_io (
      .val (io_a),
      .lo  (ent[i][15:0]),
      .hi  (ent[i][imd_pkg::LIM_LSB +: 16]),
      .hit (io_hit[i])
    );
  end

  for (genvar i = 0; i < imd_pkg::NUM_RP; i++) begin : g_br
    imd_range_hit #(.W(12)) u_br (
      .val (ma[31:20]),
      .lo  (ent[imd_pkg::NUM_IOW+i][11:0]),
      .hi  (ent[imd_pkg::NUM_IOW+i][imd_pkg::LIM_LSB +: 12]),
      .hit (br_hit[i])
    );
  end

  logic lan_win;
  imd_range_hit #(.W(12)) u_lan (
    .val (ma[31:20]),
    .lo  (lan_q[11:0]),
    .hi  (lan_q[imd_pkg::LIM_LSB +: 12]),
    .hit (lan_win)
  );

  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 15; k >= 0; k--) begin
      if (v[k]) r = 4'(k);
    end
    return r;
  endfunction

  wire [imd_pkg::NUM_RP-1:0]  rp_io  = io_hit[imd_pkg::NUM_RP-1:0];
  wire [imd_pkg::NUM_VAR-1:0] var_io = io_hit[imd_pkg::NUM_IOW-1:imd_pkg::NUM_RP];
  wire [3:0] rp_idx  = first_set({4'h0, rp_io});
  wire [3:0] var_idx = first_set({12'h000, var_io});

  // firmware windows
  wire eseg_hit = fwen_q[imd_pkg::FW_ESEG_BIT] && ma[31:16] == imd_pkg::ESEG_BLK;
  wire fseg_hit = fwen_q[imd_pkg::FW_FSEG_BIT] && ma[31:16] == imd_pkg::FSEG_BLK;
  wire hifw_in  = (ma[31:22] == imd_pkg::HIFW_TOP || ma[31:22] == imd_pkg::HIFW_ALIAS) && !ma[21];
  wire hifw_hit = hifw_in && fwen_q[imd_pkg::FW_HI_LSB + 32'(ma[20:19])];
  wire fw_hit   = eseg_hit | fseg_hit | hifw_hit;

  // internal apic; its window wins over a port apic window it lands in
  wire apic_hit = apic_q[imd_pkg::APIC_EN_BIT] && ma[31:20] == imd_pkg::APIC_HI
                  && ma[19:12] == apic_q[imd_pkg::APIC_SEL_LSB +: 8]
                  && ma[11:0] <= imd_pkg::APIC_LAST;

  wire [31:0] papic_off = ma - imd_pkg::PAPIC_FIRST;
  wire        papic_in  = ma >= imd_pkg::PAPIC_FIRST && ma <= imd_pkg::PAPIC_LAST;
  wire [3:0]  papic_idx = papic_off[18:15];
  wire        papic_hit = papic_in && pae_q[papic_idx];

  wire up_mem_any = fw_hit | apic_hit | papic_hit;

  // ****************************************************************
  // decision
  // ****************************************************************
  // fixed-range overlap is neither checked nor flagged; the legacy and variable
  // windows simply win by priority, as software is trusted to keep them apart
  always_comb begin
    rsp_d = '{tgt: imd_pkg::tgt_abort, idx: 4'h0, rd_ones: 1'b0, wr_drop: 1'b0};
    if (req.from_down) begin
      if (req.is_io || |br_hit) rsp_d.tgt = imd_pkg::tgt_peer;
      else if (lan_win) rsp_d.tgt = imd_pkg::tgt_lan;
      else rsp_d.tgt = imd_pkg::tgt_upstream;
    end else if (req.is_io) begin
      if (leg_any) begin
        rsp_d.tgt = imd_pkg::tgt_legacy;
        rsp_d.idx = leg_idx;
      end else if (|var_io) begin
        rsp_d.tgt = imd_pkg::tgt_unit;
        rsp_d.idx = var_idx;
      end else if (|rp_io) begin
        rsp_d.tgt = imd_pkg::tgt_rport;
        rsp_d.idx = rp_idx;
      end else begin
        rsp_d.tgt     = imd_pkg::tgt_term;
        rsp_d.rd_ones = 1'b1;
        rsp_d.wr_drop = 1'b1;
      end
    end else if (fw_hit) begin
      rsp_d.tgt = imd_pkg::tgt_fw;
    end else if (apic_hit) begin
      rsp_d.tgt = imd_pkg::tgt_ioapic;
    end else if (papic_hit) begin
      rsp_d.tgt = imd_pkg::tgt_rport;
      rsp_d.idx = papic_idx;
    end
  end

  // decisions reflect settings as they stand in the cycle the request is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '{tgt: imd_pkg::tgt_abort, idx: 4'h0, rd_ones: 1'b0, wr_drop: 1'b0};
      abort_cnt_q <= 16'h0000;
    end else if (ce) begin
      rsp_valid_q <= req_valid;
      if (req_valid) rsp_q <= rsp_d;
      if (req_valid && rsp_d.tgt == imd_pkg::tgt_abort && abort_cnt_q != 16'hffff)
        abort_cnt_q <= abort_cnt_q + 16'h0001;
    end
  end

  assign req_ready = ce;
  assign rsp_valid = rsp_valid_q;
  assign rsp       = rsp_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire take    = ce & req_valid;
  wire up_mem  = take & up & ~req.is_io;
  wire up_io   = take & up & req.is_io;
  wire dn_mem  = take & req.from_down & ~req.is_io;

  a_down_peer: assert property (dn_mem && |br_hit |=> rsp.tgt == imd_pkg::tgt_peer)
    else $error("bridge window cycle was claimed");
  a_down_up_fwd: assert property (dn_mem && !(|br_hit) && !lan_win
                                  |=> rsp_valid && rsp.tgt == imd_pkg::tgt_upstream)
    else $error("downstream cycle not forwarded up");
  a_mem_abort: assert property (up_mem && !up_mem_any |=> rsp.tgt == imd_pkg::tgt_abort)
    else $error("unmatched memory cycle not aborted");
  a_eseg_gate: assert property (up_mem && ma[31:16] == imd_pkg::ESEG_BLK
                                && !fwen_q[imd_pkg::FW_ESEG_BIT] |=> rsp.tgt != imd_pkg::tgt_fw)
    else $error("E segment claimed while disabled");
  a_hifw_route: assert property (up_mem && hifw_in && fwen_q[imd_pkg::FW_HI_LSB + 32'(ma[20:19])]
                                 |=> rsp.tgt == imd_pkg::tgt_fw)
    else $error("high firmware window not routed");
  a_ioapic_claim: assert property (up_mem && !fw_hit && apic_hit |=> rsp.tgt == imd_pkg::tgt_ioapic)
    else $error("apic window not claimed");
  a_port_apic_fwd: assert property (up_mem && papic_in && !apic_hit && pae_q[papic_idx]
                                    |=> rsp.tgt == imd_pkg::tgt_rport && rsp.idx == $past(papic_idx))
    else $error("port apic window misrouted");
  a_legacy_route: assert property (up_io && leg_any |=> rsp.tgt == imd_pkg::tgt_legacy)
    else $error("legacy window not forwarded");
  a_rport_io: assert property (up_io && !leg_any && !(|var_io) && |rp_io
                               |=> rsp.tgt == imd_pkg::tgt_rport && rsp.idx == $past(rp_idx))
    else $error("root port io misrouted");
  a_term_ones: assert property (rsp_valid && rsp.tgt == imd_pkg::tgt_term
                                |-> rsp.rd_ones && rsp.wr_drop && $past(up_io))
    else $error("terminated cycle lacks all ones");
  a_var_up_only: assert property (take && req.from_down |=> rsp.tgt != imd_pkg::tgt_unit)
    else $error("variable window hit from downstream");

  c_abort: cover property (rsp_valid && rsp.tgt == imd_pkg::tgt_abort);
  c_fw:    cover property (rsp_valid && rsp.tgt == imd_pkg::tgt_fw);
  c_rport: cover property (rsp_valid && rsp.tgt == imd_pkg::tgt_rport);
  c_peer:  cover property (rsp_valid && rsp.tgt == imd_pkg::tgt_peer);

endmodule
`default_nettype wire

// ---- logic/imd_pkg.sv ----
// decoder package: register map, field layout, window locations and carriers
// ****************************************************************************
// Notes on behaviour
// - Variable I/O windows are decoded only for upstream link cycles, from each window's base and limit.
// - No check is made for variable windows overlapping fixed I/O ranges, and no flag is raised.
// - An 8-byte parallel-port window sits at one of three selectable places and goes to the legacy bus.
// - Two 8-byte serial-port windows each sit at one of eight places and go to the legacy bus.
// - An 8-byte floppy window sits at one of two places and goes to the legacy bus.
// - I/O cycles inside a root port's I/O base and limit go to that port, for ports 1 to 12.
// - An upstream memory cycle that hits no internal memory target is master aborted.
// - Downstream master memory cycles are claimed unless they fall in a bridge forwarding window.
// - A claimed downstream memory cycle outside the network controller range goes up the link.
// - The E and F segment firmware windows are claimed only when enable bits 6 and 7 are set.
// - Each 512 KB high firmware window and its lower alias are claimed when enable bit 8 to 11 is set.
// - The I/O APIC window is claimed only when enabled, its middle digits set by the select field.
// - Consecutive 32 KB APIC windows go to root ports 1 to 12, each only when its forward enable is set.
// - Upstream cycles to reserved or unclaimed I/O are ended inside: writes dropped, reads all ones.
// ****************************************************************************
package imd_pkg;

  localparam int NUM_RP  = 12;
  localparam int NUM_VAR = 4;
  localparam int NUM_IOW = NUM_RP + NUM_VAR;
  localparam int NUM_ENT = NUM_IOW + NUM_RP;

  // register offsets
  localparam logic [11:0] FWEN_OFF = 12'h000;
  localparam logic [11:0] APIC_OFF = 12'h004;
  localparam logic [11:0] PAE_OFF  = 12'h008;
  localparam logic [11:0] LEG_OFF  = 12'h00c;
  localparam logic [11:0] LAN_OFF  = 12'h010;
  localparam logic [11:0] STAT_OFF = 12'h014;
  localparam logic [11:0] TBL_OFF  = 12'h100;

  // reset values; a window entry resets to base above limit, so it never hits
  localparam logic [31:0] FWEN_RST = 32'h0000_0000;
  localparam logic [31:0] APIC_RST = 32'h0000_0000;
  localparam logic [31:0] PAE_RST  = 32'h0000_0000;
  localparam logic [31:0] LEG_RST  = 32'h0000_0000;
  localparam logic [31:0] LAN_RST  = 32'h0000_0fff;
  localparam logic [31:0] ENT_RST  = 32'h0000_ffff;

  // field positions
  localparam int FW_ESEG_BIT  = 6;
  localparam int FW_FSEG_BIT  = 7;
  localparam int FW_HI_LSB    = 8;
  localparam int APIC_EN_BIT  = 0;
  localparam int APIC_SEL_LSB = 8;
  localparam int PAR_EN_BIT   = 0;
  localparam int PAR_SEL_LSB  = 1;
  localparam int SER1_EN_BIT  = 4;
  localparam int SER1_SEL_LSB = 5;
  localparam int SER2_EN_BIT  = 8;
  localparam int SER2_SEL_LSB = 9;
  localparam int FDC_EN_BIT   = 12;
  localparam int FDC_SEL_BIT  = 13;
  localparam int LIM_LSB      = 16;

  // address constants
  localparam logic [15:0] ESEG_BLK    = 16'h000e;
  localparam logic [15:0] FSEG_BLK    = 16'h000f;
  localparam logic [9:0]  HIFW_TOP    = 10'h3ff;
  localparam logic [9:0]  HIFW_ALIAS  = 10'h3fe;
  localparam logic [11:0] APIC_HI     = 12'hfec;
  localparam logic [11:0] APIC_LAST   = 12'h040;
  localparam logic [31:0] PAPIC_FIRST = 32'hfec1_0000;
  localparam logic [31:0] PAPIC_LAST  = 32'hfec6_ffff;

  // selectable legacy window locations
  localparam logic [15:0] PAR_LOC [3] = '{16'h0378, 16'h0278, 16'h03bc};
  localparam logic [15:0] SER_LOC [8] = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228,
                                          16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
  localparam logic [15:0] FDC_LOC [2] = '{16'h03f0, 16'h0370};

  typedef struct packed {
    logic [31:0] addr;
    logic        is_io;
    logic        is_write;
    logic        from_down;
  } imd_req_t;

  typedef enum logic [3:0] {
    tgt_abort, tgt_term, tgt_legacy, tgt_rport, tgt_unit,
    tgt_fw, tgt_ioapic, tgt_upstream, tgt_lan, tgt_peer
  } imd_tgt_t;

  typedef struct packed {
    imd_tgt_t   tgt;
    logic [3:0] idx;
    logic       rd_ones;
    logic       wr_drop;
  } imd_rsp_t;

endpackage

// ---- logic/imd_range_hit.sv ----
// inclusive base/limit window comparator
`timescale 1ns/1ps
`default_nettype none
module imd_range_hit #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] val,  // address bits under test
  input  wire logic [W-1:0] lo,   // window base
  input  wire logic [W-1:0] hi,   // window limit
  output logic              hit   // inside window
);
  // base above limit reads as a closed window
  assign hit = (val >= lo) && (val <= hi);
endmodule
`default_nettype wire

// ---- logic/imd_win_table.sv ----
// window settings table: parallel view for decode, registered read port
`timescale 1ns/1ps
`default_nettype none
module imd_win_table #(
  parameter int          N   = 28,
  parameter logic [31:0] RST = 32'h0000_ffff
) (
  input  wire logic                 clk,      // clock
  input  wire logic                 rst_n,    // async reset, low
  input  wire logic                 ce,       // clock enable
  input  wire logic                 wr_en,    // write strobe
  input  wire logic [4:0]           wr_idx,   // write entry
  input  wire logic [31:0]          wr_data,  // merged write word
  input  wire logic                 rd_en,    // read load strobe
  input  wire logic [4:0]           rd_idx,   // read entry
  output logic      [31:0]          rd_data,  // registered read word
  output logic      [N-1:0][31:0]   ent       // all entries
);
  logic [N-1:0][31:0] ent_q;

  for (genvar i = 0; i < N; i++) begin : g_ent
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ent_q[i] <= RST;
      else if (ce && wr_en && wr_idx == 5'(i)) ent_q[i] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_data <= 32'h0000_0000;
    else if (ce && rd_en) rd_data <= ent_q[rd_idx];
  end

  assign ent = ent_q;
endmodule
`default_nettype wire

// ---- sim/imd_decoder_tb.sv ----
// self-checking bench for the address decoder
`timescale 1ns/1ps
`default_nettype none
module imd_decoder_tb;
  typedef struct packed {
    logic [31:0]       a;
    logic [1:0]        k;
    imd_pkg::imd_tgt_t t;
    logic [3:0]        ix;
  } imd_row_t;
  logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic              req_valid, req_ready, rsp_valid;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  imd_pkg::imd_req_t req;
  imd_pkg::imd_rsp_t rsp;
  imd_row_t          rows[$];
  int                error_cnt, samples_checked;

  imd_decoder uut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));
  imd_host_model host (.pclk(pclk), .req_ready(req_ready), .req_valid(req_valid), .req(req));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************************
  // bus and decode helpers
  // ****************************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic add(input logic [31:0] a, input logic [1:0] k, input imd_pkg::imd_tgt_t t,
                     input logic [3:0] ix);
    rows.push_back('{a, k, t, ix});
  endtask

  task automatic dec(input imd_row_t r, input logic wr);
    host.send(r.a, r.k, wr);
    // look mid-cycle, away from the edge that moves the response
    @(negedge pclk);
    chk(32'(rsp_valid), 32'h1);
    chk(32'(rsp.tgt), 32'(r.t));
    if (r.t inside {imd_pkg::tgt_legacy, imd_pkg::tgt_rport, imd_pkg::tgt_unit})
      chk(32'(rsp.idx), 32'(r.ix));
    @(posedge pclk);
  endtask

  // ****************************************************************************
  // main sequence
  // ****************************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    ce = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0000_0fff);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0000_ffff);
    apb(1'b1, 12'h000, 32'h0000_0140);
    apb(1'b1, 12'h004, 32'h0000_2001);
    apb(1'b1, 12'h008, 32'h0000_0801);
    apb(1'b1, 12'h00c, 32'h0000_30f3);
    apb(1'b1, 12'h010, 32'h080f_0800);
    apb(1'b1, 12'h100, 32'h1fff_1000);
    // unit window kept clear of every fixed range
    apb(1'b1, 12'h130, 32'h201f_2000);
    apb(1'b1, 12'h140, 32'h090f_0900);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0000_30f3);
    apb(1'b0, 12'h018, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    add(32'h000e_0010, 2'd0, imd_pkg::tgt_fw, 4'h0);
    add(32'h000f_0010, 2'd0, imd_pkg::tgt_abort, 4'h0);
    add(32'hffc0_0000, 2'd0, imd_pkg::tgt_fw, 4'h0);
    add(32'hff87_ffff, 2'd0, imd_pkg::tgt_fw, 4'h0);
    add(32'hffc8_0000, 2'd0, imd_pkg::tgt_abort, 4'h0);
    add(32'hfec2_0040, 2'd0, imd_pkg::tgt_ioapic, 4'h0);
    add(32'hfec2_0041, 2'd0, imd_pkg::tgt_abort, 4'h0);
    add(32'hfec1_0000, 2'd0, imd_pkg::tgt_rport, 4'h0);
    add(32'hfec6_7fff, 2'd0, imd_pkg::tgt_abort, 4'h0);
    add(32'hfec6_ffff, 2'd0, imd_pkg::tgt_rport, 4'hb);
    add(32'h0000_0278, 2'd2, imd_pkg::tgt_legacy, 4'h0);
    add(32'h0000_027f, 2'd2, imd_pkg::tgt_legacy, 4'h0);
    add(32'h0000_0378, 2'd2, imd_pkg::tgt_term, 4'h0);
    add(32'h0000_03ef, 2'd2, imd_pkg::tgt_legacy, 4'h1);
    add(32'h0000_03f8, 2'd2, imd_pkg::tgt_term, 4'h0);
    add(32'h0000_0370, 2'd2, imd_pkg::tgt_legacy, 4'h3);
    add(32'h0000_03f0, 2'd2, imd_pkg::tgt_term, 4'h0);
    add(32'h0000_1fff, 2'd2, imd_pkg::tgt_rport, 4'h0);
    add(32'h0000_2000, 2'd2, imd_pkg::tgt_unit, 4'h0);
    add(32'h0000_2020, 2'd2, imd_pkg::tgt_term, 4'h0);
    add(32'h0000_2000, 2'd3, imd_pkg::tgt_peer, 4'h0);
    add(32'h8050_0000, 2'd1, imd_pkg::tgt_lan, 4'h0);
    add(32'h9090_0000, 2'd1, imd_pkg::tgt_peer, 4'h0);
    add(32'h7000_0000, 2'd1, imd_pkg::tgt_upstream, 4'h0);
    add(32'h000e_0010, 2'd1, imd_pkg::tgt_upstream, 4'h0);
    foreach (rows[i])
      dec(rows[i], 1'b0);
    // unclaimed write: dropped inside, reads give all ones
    dec('{32'h0000_0280, 2'd2, imd_pkg::tgt_term, 4'h0}, 1'b1);
    chk(32'({rsp.rd_ones, rsp.wr_drop}), 32'h3);
    @(negedge pclk);
    chk(32'(rsp_valid), 32'h0);
    // four aborts so far, last decision a terminated io cycle
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000_0401);
    apb(1'b1, 12'h000, 32'h0);
    dec('{32'h000e_0010, 2'd0, imd_pkg::tgt_abort, 4'h0}, 1'b0);
    // reset again mid-run: counters and settings must clear
    presetn <= 1'b0;
    @(negedge pclk);
    chk(32'(rsp_valid), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0000_0000);
    // a write with the clock enable low must not land; then one byte lane only
    ce <= 1'b0;
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    ce    <= 1'b1;
    pstrb <= 4'h2;
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    pstrb <= 4'hf;
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0000_ff00);
    tally_and_finish();
  end

  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- sim/imd_host_model.sv ----
// host side model: offers decode cycles and holds each one until it is taken
`timescale 1ns/1ps
`default_nettype none
module imd_host_model (
  input  wire logic         pclk,       // clock
  input  wire logic         req_ready,  // cycle taken
  output logic              req_valid,  // cycle offered
  output imd_pkg::imd_req_t req         // cycle address and kind
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // plain cycles only, a locked access is never offered
  task automatic send(input logic [31:0] a, input logic [1:0] k, input logic wr);
    req_valid <= 1'b1;
    req       <= '{addr: a, is_io: k[1], is_write: wr, from_down: k[0]};
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // released lines must not keep the last address
    req.addr  <= ~a;
  endtask
endmodule
`default_nettype wire
